// ===== logic/interlock_cfg.svh
/*
   Constants for the tape transport safety interlock: debounce length, clock rate,
   field widths and selector encodings.
   Assumes it is included by bare name from logic/ and holds definitions only.
*/
// Overview of operation
// - No mode starts while tension sensing shows no tape threaded.
// - Tension lost while moving applies brakes and halts motion at once.
// - Tape run off either reel applies brakes so both reels stop.
// - Optical end sensors on either reel stop the transport.
// - After an optical end stop, any mode is accepted again.
// - Defeat switch off makes the optical end sensors ignored.
// - Brake release requires power present; power loss applies brakes.
// - Record electronics on only while running in record, or under test.
// - Record needs record button held while a run button is pressed, released.
// - Test setting lights record lamp, powers record electronics, inhibits motion.
// - Bias enabled whenever record relay energized or test selected.
// - Reproduce electronics enabled in every operating mode.
// - Selected speed picks the matching speed equalization elements.
// - Bandwidth selector picks normal or double-bandwidth equalization.
// - Slave transfer selector sets run direction for transfer unless off.
// - Transmitter closes transfer contact when recording and optical end activates.
// - Receiver ignores transfer when off, else record reverse or forward.
`ifndef INTERLOCK_CFG_SVH
`define INTERLOCK_CFG_SVH
`define DEB_TIME_US 10
`define CLK_MHZ 100
`define DEB_CYCLES (`DEB_TIME_US * `CLK_MHZ)
`define DEB_W 20
`define NUM_IN 21
`define SPEED_W 4
`define EQ_W 11
`define SEL_OFF 2'h0
`define SEL_REV 2'h1
`define SEL_FWD 2'h2
`define MODE_W 3
`endif

// ===== logic/interlock_pkg.sv
/*
   Types for the tape transport safety interlock.
   Assumes interlock_cfg.svh is available.
*/
`include "interlock_cfg.svh"
package interlock_pkg;
   typedef enum logic [`MODE_W-1:0] {
      ST_STOP = 3'b000,
      ST_RUN_FWD = 3'b001,
      ST_RUN_REV = 3'b010,
      ST_FAST_FWD = 3'b011,
      ST_FAST_REV = 3'b100,
      ST_REC_FWD = 3'b101,
      ST_REC_REV = 3'b110
   } mode_t;
endpackage

// ===== logic/tape_transport_safety_interlock.sv
/*
   Safety interlock and equalisation control for a reel-to-reel tape transport.
   Assumes panel switches and sensors arrive asynchronously on plain pins, and that
   the clock runs at 100 MHz whenever power logic is alive.
*/
`timescale 1ns/1ps
`include "interlock_cfg.svh"
module tape_transport_safety_interlock (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Operator buttons, momentary.
   input wire logic record_btn_in,
   input wire logic run_fwd_btn_in,
   input wire logic run_rev_btn_in,
   input wire logic fast_fwd_btn_in,
   input wire logic fast_rev_btn_in,
   input wire logic stop_btn_in,
   // Panel switches.
   input wire logic record_test_select_in,
   input wire logic end_sense_defeat_switch_in,
   input wire logic [1:0] handover_selector_switch_in,
   input wire logic bandwidth_selector_switch_in,
   input wire logic [`SPEED_W-1:0] speed_select_in,
   // Sensors and status.
   input wire logic tension_ok_in,
   input wire logic upper_reel_empty_in,
   input wire logic lower_reel_empty_in,
   input wire logic optical_tape_end_sense_in,
   input wire logic power_ok_in,
   input wire logic handover_enable_in,
   // Motion and brake outputs.
   output logic brake_release_out,
   output logic [`MODE_W-1:0] mode_out,
   output logic forward_direction_out,
   output logic reverse_direction_out,
   // Electronics enables.
   output logic record_enable_out,
   output logic bias_enable_out,
   output logic reproduce_enable_out,
   output logic [`EQ_W-1:0] speed_eq_out,
   output logic bandwidth_eq_select_out,
   // Lamps and transfer contact.
   output logic record_lamp_out,
   output logic stop_lamp_out,
   output logic ready_lamp_out,
   output logic handover_contact_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Input conditioning: two flops then a debounce counter per input.
   // The 10 us count keeps panel latency short; contacts that bounce longer need a larger count.
   logic [`NUM_IN-1:0] raw_w;
   logic [`NUM_IN-1:0] sync1_r;
   logic [`NUM_IN-1:0] sync2_r;
   logic [`NUM_IN-1:0] clean_r;
   assign raw_w = {speed_select_in, bandwidth_selector_switch_in, handover_selector_switch_in, run_rev_btn_in,
                   run_fwd_btn_in, record_btn_in, handover_enable_in, power_ok_in, optical_tape_end_sense_in,
                   lower_reel_empty_in, upper_reel_empty_in, tension_ok_in, record_test_select_in,
                   end_sense_defeat_switch_in, stop_btn_in, fast_rev_btn_in, fast_fwd_btn_in};

   // Double-flop synchroniser; only the second stage is read by logic.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_r <= {`NUM_IN{1'b0}};
         sync2_r <= {`NUM_IN{1'b0}};
      end else begin
         sync1_r <= raw_w;
         sync2_r <= sync1_r;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `NUM_IN; gi = gi + 1) begin : g_deb
         logic [`DEB_W-1:0] cnt_r;
         // Accept a new level only after it has been stable for the full count.
         always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               cnt_r <= {`DEB_W{1'b0}};
               clean_r[gi] <= 1'b0;
            end else if (sync2_r[gi] == clean_r[gi]) begin
               cnt_r <= {`DEB_W{1'b0}};
            end else if (cnt_r == `DEB_W'(`DEB_CYCLES - 1)) begin
               cnt_r <= {`DEB_W{1'b0}};
               clean_r[gi] <= sync2_r[gi];
            end else begin
               cnt_r <= cnt_r + `DEB_W'(1);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Named views of the conditioned inputs.
   wire run_fwd_w = clean_r[12];
   wire run_rev_w = clean_r[13];
   wire rec_btn_w = clean_r[11];
   wire [1:0] xfer_sel_w = clean_r[15:14];
   wire bw_sel_w = clean_r[16];
   wire fast_fwd_w = clean_r[0];
   wire fast_rev_w = clean_r[1];
   wire stop_w = clean_r[2];
   wire defeat_on_w = clean_r[3];
   wire test_w = clean_r[4];
   wire tension_w = clean_r[5];
   wire reel_empty_w = clean_r[6] | clean_r[7];
   wire opt_end_w = clean_r[8] & defeat_on_w;
   wire power_w = clean_r[9];
   wire xfer_cmd_w = clean_r[10];
   wire [`SPEED_W-1:0] speed_w = clean_r[20:17];

   ////////////////////////////////////////////////////////////////////////////
   // Record arming: record held while a run button is pressed and released.
   logic armed_fwd_r;
   logic armed_rev_r;
   logic run_fwd_d_r;
   logic run_rev_d_r;
   logic opt_end_d_r;
   logic xfer_d_r;
   wire fwd_rel_w = run_fwd_d_r & ~run_fwd_w;
   wire rev_rel_w = run_rev_d_r & ~run_rev_w;
   wire opt_rise_w = opt_end_w & ~opt_end_d_r;
   wire xfer_rise_w = xfer_cmd_w & ~xfer_d_r;

   // Run release with record still held arms record; a plain run release does not.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         armed_fwd_r <= 1'b0;
         armed_rev_r <= 1'b0;
         run_fwd_d_r <= 1'b0;
         run_rev_d_r <= 1'b0;
         opt_end_d_r <= 1'b0;
         xfer_d_r <= 1'b0;
      end else begin
         run_fwd_d_r <= run_fwd_w;
         run_rev_d_r <= run_rev_w;
         opt_end_d_r <= opt_end_w;
         xfer_d_r <= xfer_cmd_w;
         if (!rec_btn_w) begin
            armed_fwd_r <= 1'b0;
            armed_rev_r <= 1'b0;
         end else begin
            armed_fwd_r <= armed_fwd_r | fwd_rel_w;
            armed_rev_r <= armed_rev_r | rev_rel_w;
         end
      end
   end
   wire rec_fwd_go_w = armed_fwd_r & ~rec_btn_w;
   wire rec_rev_go_w = armed_rev_r & ~rec_btn_w;

   ////////////////////////////////////////////////////////////////////////////
   // Mode machine. Halting conditions are checked first every cycle.
   interlock_pkg::mode_t mode_r;
   interlock_pkg::mode_t mode_nxt;
   // Optical end only stops on its rising edge, so later commands are accepted.
   wire halt_w = ~tension_w | reel_empty_w | ~power_w | test_w | stop_w | opt_rise_w;
   wire start_ok_w = tension_w & ~reel_empty_w & power_w & ~test_w;

   always_comb begin
      mode_nxt = mode_r;
      if (halt_w) begin
         mode_nxt = interlock_pkg::ST_STOP;
      end else if (start_ok_w) begin
         // Optical end does not block new commands after its stop.
         if (rec_fwd_go_w) begin
            mode_nxt = interlock_pkg::ST_REC_FWD;
         end else if (rec_rev_go_w) begin
            mode_nxt = interlock_pkg::ST_REC_REV;
         end else if (xfer_rise_w && xfer_sel_w == `SEL_REV) begin
            mode_nxt = interlock_pkg::ST_REC_REV;
         end else if (xfer_rise_w && xfer_sel_w == `SEL_FWD) begin
            mode_nxt = interlock_pkg::ST_REC_FWD;
         end else if (fwd_rel_w && !rec_btn_w) begin
            mode_nxt = interlock_pkg::ST_RUN_FWD;
         end else if (rev_rel_w && !rec_btn_w) begin
            mode_nxt = interlock_pkg::ST_RUN_REV;
         end else if (fast_fwd_w) begin
            mode_nxt = interlock_pkg::ST_FAST_FWD;
         end else if (fast_rev_w) begin
            mode_nxt = interlock_pkg::ST_FAST_REV;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_r <= interlock_pkg::ST_STOP;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output decode as named wires.
   logic fwd_w;
   logic rev_w;
   logic rec_w;
   always_comb begin
      case (mode_r)
         interlock_pkg::ST_RUN_FWD, interlock_pkg::ST_FAST_FWD, interlock_pkg::ST_REC_FWD: begin
            fwd_w = 1'b1;
            rev_w = 1'b0;
         end
         interlock_pkg::ST_RUN_REV, interlock_pkg::ST_FAST_REV, interlock_pkg::ST_REC_REV: begin
            fwd_w = 1'b0;
            rev_w = 1'b1;
         end
         default: begin
            fwd_w = 1'b0;
            rev_w = 1'b0;
         end
      endcase
   end
   assign rec_w = (mode_r == interlock_pkg::ST_REC_FWD) || (mode_r == interlock_pkg::ST_REC_REV);
   wire moving_nxt_w = (mode_nxt != interlock_pkg::ST_STOP);

   // One-hot speed equalisation selection; unknown codes select none.
   function automatic logic [`EQ_W-1:0] speed_eq_f(input logic [`SPEED_W-1:0] s);
      speed_eq_f = (s < `SPEED_W'(`EQ_W)) ? (`EQ_W'(1) << s) : {`EQ_W{1'b0}};
   endfunction

   // Registered outputs. Brake release uses the next mode and live power so a
   // fault reaches the brake in the same cycle as the mode drops.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         brake_release_out <= 1'b0;
         mode_out <= `MODE_W'(0);
         forward_direction_out <= 1'b0;
         reverse_direction_out <= 1'b0;
         record_enable_out <= 1'b0;
         bias_enable_out <= 1'b0;
         reproduce_enable_out <= 1'b0;
         speed_eq_out <= {`EQ_W{1'b0}};
         bandwidth_eq_select_out <= 1'b0;
         record_lamp_out <= 1'b0;
         stop_lamp_out <= 1'b0;
         ready_lamp_out <= 1'b0;
         handover_contact_out <= 1'b0;
      end else begin
         brake_release_out <= moving_nxt_w & power_w & ~halt_w;
         mode_out <= mode_r;
         forward_direction_out <= fwd_w;
         reverse_direction_out <= rev_w;
         record_enable_out <= rec_w | test_w;
         bias_enable_out <= rec_w | test_w;
         reproduce_enable_out <= power_w;
         speed_eq_out <= speed_eq_f(speed_w);
         bandwidth_eq_select_out <= bw_sel_w;
         record_lamp_out <= rec_w | test_w;
         stop_lamp_out <= power_w & (mode_r == interlock_pkg::ST_STOP);
         ready_lamp_out <= power_w & tension_w & ~test_w;
         handover_contact_out <= (rec_w & opt_end_w) | (handover_contact_out & opt_end_w);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the mode register and the outputs this block drives.
   property p_no_tension_brake;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      !tension_w |=> !brake_release_out;
   endproperty
   a_no_tension_brake: assert property (p_no_tension_brake) else $error("brake released without tension");

   property p_reel_empty_stop;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      reel_empty_w |=> mode_r == interlock_pkg::ST_STOP;
   endproperty
   a_reel_empty_stop: assert property (p_reel_empty_stop) else $error("empty reel did not stop");

   property p_opt_end_stop;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      opt_rise_w |=> mode_r == interlock_pkg::ST_STOP;
   endproperty
   a_opt_end_stop: assert property (p_opt_end_stop) else $error("optical end did not stop");

   property p_power_brake;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      !power_w |=> !brake_release_out;
   endproperty
   a_power_brake: assert property (p_power_brake) else $error("brake released without power");

   property p_record_gate;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(record_enable_out) |-> $past(rec_w) || $past(test_w);
   endproperty
   a_record_gate: assert property (p_record_gate) else $error("record enabled outside record");

   property p_test_no_motion;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      test_w |=> (mode_r == interlock_pkg::ST_STOP) && record_lamp_out;
   endproperty
   a_test_no_motion: assert property (p_test_no_motion) else $error("test mode moved tape");

   property p_bias;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (rec_w || test_w) |=> bias_enable_out;
   endproperty
   a_bias: assert property (p_bias) else $error("bias missing");

   property p_no_thread_start;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (!tension_w && mode_r == interlock_pkg::ST_STOP) |=> mode_r == interlock_pkg::ST_STOP;
   endproperty
   a_no_thread_start: assert property (p_no_thread_start) else $error("started without tape");

   property p_xfer_off;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (xfer_rise_w && xfer_sel_w == `SEL_OFF && mode_r == interlock_pkg::ST_STOP && !rec_fwd_go_w
       && !rec_rev_go_w && !fwd_rel_w && !rev_rel_w && !fast_fwd_w && !fast_rev_w)
      |=> mode_r == interlock_pkg::ST_STOP;
   endproperty
   a_xfer_off: assert property (p_xfer_off) else $error("transfer accepted while off");
endmodule

// ===== verification/panel_sensor_model.sv
/*
   Behavioural model of the operator panel and tape sensors that face the interlock.
   Assumes the bench calls its tasks in sequence and that inputs change at falling edges.
*/
`timescale 1ns/1ps
`include "interlock_cfg.svh"
module panel_sensor_model (
   // Clock used to pace panel actions.
   input wire logic clk_in,
   // Buttons and switches.
   output logic [5:0] btn_out,
   output logic test_out,
   output logic defeat_out,
   output logic [1:0] hsel_out,
   output logic bw_out,
   output logic [`SPEED_W-1:0] speed_out,
   // Sensors.
   output logic tension_out,
   output logic upper_empty_out,
   output logic lower_empty_out,
   output logic opt_end_out,
   output logic power_out,
   output logic handover_out
);
   // Every action must outlast the interlock's debounce count before it is seen.
   localparam int HOLD = `DEB_CYCLES + 40;
   // All lines but the defeat switch start released, unpowered and without tape, as on a cold panel; defeat starts high.
   initial begin
      {btn_out, test_out, hsel_out, bw_out, speed_out, tension_out} = '0;
      {upper_empty_out, lower_empty_out, opt_end_out, power_out, handover_out} = '0;
      defeat_out = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Sensor and switch settings change together so one settling time covers them.
   task automatic set_sense(input logic ten, input logic pwr, input logic tst, input logic opt,
                            input logic reel, input logic [`SPEED_W-1:0] spd);
      @(negedge clk_in);
      {tension_out, power_out, test_out, opt_end_out, lower_empty_out, speed_out} = {ten, pwr, tst, opt, reel, spd};
   endtask
   // Selector switches; the caller waits out the debounce time.
   task automatic set_sel(input logic bw, input logic [1:0] hs);
      @(negedge clk_in);
      {bw_out, hsel_out} = {bw, hs};
   endtask
   // End sensing defeat switch; low means the optical end sensors are overridden.
   task automatic set_defeat(input logic on);
      @(negedge clk_in);
      defeat_out = on;
   endtask
   // A button is pressed and released, each level held past the debounce time.
   task automatic tap(input int idx);
      @(negedge clk_in);
      btn_out[idx] = 1'b1;
      repeat (HOLD) @(negedge clk_in);
      btn_out[idx] = 1'b0;
      repeat (HOLD) @(negedge clk_in);
   endtask
   // Transfer closure from a transmitting transport, made and then broken.
   task automatic close_handover();
      @(negedge clk_in);
      handover_out = 1'b1;
      repeat (HOLD) @(negedge clk_in);
      handover_out = 1'b0;
      repeat (HOLD) @(negedge clk_in);
   endtask
   // Record is held across the whole press and release of a run button, then released.
   task automatic record_run(input int idx);
      @(negedge clk_in);
      btn_out[0] = 1'b1;
      repeat (HOLD) @(negedge clk_in);
      tap(idx);
      btn_out[0] = 1'b0;
      repeat (HOLD) @(negedge clk_in);
   endtask
endmodule

// ===== verification/test_tape_transport_safety_interlock.sv
/*
   Self-checking bench for the tape transport safety interlock.
   Assumes the design's full debounce time, so each sensor change costs one settling period.
*/
`timescale 1ns/1ps
`include "interlock_cfg.svh"
module test_tape_transport_safety_interlock;
   localparam int DEB_WAIT = `DEB_CYCLES + 40;
   localparam int LIMIT = 40 * DEB_WAIT;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   wire logic [5:0] btn;
   wire logic test_sw, defeat_sw, bw_sw, tension, up_empty, lo_empty, opt_end, power, handover;
   wire logic [1:0] hsel;
   wire logic [`SPEED_W-1:0] speed;
   logic brake_release_out, forward_direction_out, reverse_direction_out, record_enable_out;
   logic bias_enable_out, reproduce_enable_out, bandwidth_eq_select_out, record_lamp_out;
   logic stop_lamp_out, ready_lamp_out, handover_contact_out;
   logic [`MODE_W-1:0] mode_out;
   logic [`EQ_W-1:0] speed_eq_out;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;
   int m_mode = 0;
   // Free-running 100 MHz clock.
   always #5 ref_clk_in = ~ref_clk_in;
   panel_sensor_model pm (.clk_in(ref_clk_in), .btn_out(btn), .test_out(test_sw), .defeat_out(defeat_sw),
      .hsel_out(hsel), .bw_out(bw_sw), .speed_out(speed), .tension_out(tension), .upper_empty_out(up_empty),
      .lower_empty_out(lo_empty), .opt_end_out(opt_end), .power_out(power), .handover_out(handover));
   tape_transport_safety_interlock DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .record_btn_in(btn[0]),
      .run_fwd_btn_in(btn[1]), .run_rev_btn_in(btn[2]), .fast_fwd_btn_in(btn[3]), .fast_rev_btn_in(btn[4]),
      .stop_btn_in(btn[5]), .record_test_select_in(test_sw), .end_sense_defeat_switch_in(defeat_sw),
      .handover_selector_switch_in(hsel), .bandwidth_selector_switch_in(bw_sw), .speed_select_in(speed),
      .tension_ok_in(tension), .upper_reel_empty_in(up_empty), .lower_reel_empty_in(lo_empty),
      .optical_tape_end_sense_in(opt_end), .power_ok_in(power), .handover_enable_in(handover),
      .brake_release_out(brake_release_out), .mode_out(mode_out), .forward_direction_out(forward_direction_out),
      .reverse_direction_out(reverse_direction_out), .record_enable_out(record_enable_out),
      .bias_enable_out(bias_enable_out), .reproduce_enable_out(reproduce_enable_out), .speed_eq_out(speed_eq_out),
      .bandwidth_eq_select_out(bandwidth_eq_select_out), .record_lamp_out(record_lamp_out),
      .stop_lamp_out(stop_lamp_out), .ready_lamp_out(ready_lamp_out), .handover_contact_out(handover_contact_out));
   ////////////////////////////////////////////////////////////////////////////////
   // Case equality keeps an unknown output from passing as a match.
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Every output but the handover contact is predicted from the model mode and the stimulus lines alone.
   task automatic check_all(input string tname);
      logic run;
      logic rec;
      run = (m_mode != 0);
      rec = (m_mode >= 5) || test_sw;
      check("mode", 16'(mode_out), 16'(m_mode));
      check("brake release", 16'(brake_release_out), 16'(power && run));
      check("forward", 16'(forward_direction_out), 16'(m_mode inside {1, 3, 5}));
      check("reverse", 16'(reverse_direction_out), 16'(m_mode inside {2, 4, 6}));
      check("record enable", 16'(record_enable_out), 16'(rec));
      check("bias enable", 16'(bias_enable_out), 16'(rec));
      check("record lamp", 16'(record_lamp_out), 16'(rec));
      check("reproduce", 16'(reproduce_enable_out), 16'(power));
      check("stop lamp", 16'(stop_lamp_out), 16'(power && !run));
      check("ready lamp", 16'(ready_lamp_out), 16'(power && tension && !test_sw));
      check("speed eq", 16'(speed_eq_out), (speed <= 10) ? (16'h0001 << speed) : 16'h0000);
      check("bandwidth eq", 16'(bandwidth_eq_select_out), 16'(bw_sw));
      $display("test %s done", tname);
   endtask
   // A hang is cut short well after the longest expected run.
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         $display("ERROR timeout expected %0d seen %0d", LIMIT - 1, cycles);
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence; each sensor change waits one full debounce period.
   initial begin
      void'($urandom(32'h3EAFC81F));
      repeat (10) @(posedge ref_clk_in);
      @(negedge ref_clk_in) rst_n_in = 1'b1;
      check("reset brake", 16'(brake_release_out), 16'h0000);
      check("reset mode", 16'(mode_out), 16'h0000);
      pm.set_sense(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'($urandom % 11));
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      check_all("threaded idle");
      for (int i = 0; i < 4; i++) begin
         pm.set_sel(1'($urandom), 2'h0);
         repeat (DEB_WAIT) @(negedge ref_clk_in);
         check_all("bandwidth");
      end
      // A transfer closure with the selector at forward starts record forward.
      pm.set_sel(bw_sw, 2'h2);
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      pm.close_handover();
      m_mode = 5;
      check_all("transfer forward");
      pm.tap(5);
      m_mode = 0;
      check_all("stop button");
      // With the selector off the same closure must be ignored.
      pm.set_sel(bw_sw, 2'h0);
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      pm.close_handover();
      check_all("transfer off");
      pm.tap(1);
      m_mode = 1;
      check_all("run alone");
      // With end sensing defeated an optical end must not stop the run.
      pm.set_defeat(1'b0);
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      pm.set_sense(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, speed);
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      check_all("end sensing defeated");
      pm.set_sense(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, speed);
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      pm.set_defeat(1'b1);
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      pm.record_run(2);
      m_mode = 6;
      check("handover contact", 16'(handover_contact_out), 16'h0000);
      check_all("record reverse");
      pm.set_sense(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, speed);
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      m_mode = 0;
      check("handover contact", 16'(handover_contact_out), 16'h0001);
      check_all("optical end stop");
      pm.tap(3);
      m_mode = 3;
      check_all("restart after end");
      pm.set_sense(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, speed);
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      m_mode = 0;
      check_all("slack and reel out");
      pm.tap(1);
      check_all("no start unthreaded");
      pm.set_sense(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, speed);
      repeat (DEB_WAIT) @(negedge ref_clk_in);
      check_all("record test");
      pm.tap(3);
      check_all("test inhibits motion");
      stop_test();
   end
endmodule
